// ==== hdl/drs_pkg.sv ====
// Constants, register map and state type for the drive run sequencer.
// Assumes a single 125 MHz clock and an Avalon-MM register master.
// What this block does
// - Run commands need permit, halts negated, healthy, remote.
// - Forward and reverse together mean stop unless jog is set.
// - Run_accepted advances to ready on contactor feedback.
// - Permit dropped while running coasts the motor.
// - Quick-halt-negated low ramps speed to zero.
// - Quick halt latched until ramp reaches zero.
// - Freewheel halt coasts, latched until stop completes.
// - Direction invert reverses the demanded rotation.
// - Fault-clear rising edge clears all latched trips.
// - Run rising edge clears trips when option set.
// - Autostart runs at power-up, else needs edge.
// - Active, jog and halting flags, false after reset.
// - Run_accepted drives coil and starts the timer.
// - No feedback before timeout trips contactor fault.
// - Ready-to-switch-on flag when start enabled next.
// - Run-accepted flag while awaiting contactor feedback.
// - Ready flag when power stage is operable.
// - Entry flag pulses one execution cycle on run.
// - State code zero to seven, resets to zero.
// - Demanded reverse combines direction and reverse command.
// - Health cleared on trip, set on run removal.
// - Fan request held sixty seconds after conditions drop.
`default_nettype none
package drs_pkg;
   // Clock and execution cycle timing
   localparam int CLK_HZ = 125_000_000;
   localparam int EXEC_PERIOD_US = 1000;
   localparam int EXEC_CYCLES = CLK_HZ / 1_000_000 * EXEC_PERIOD_US;
   localparam int TENTH_S_MS = 100;
   localparam int TENTH_TICKS = TENTH_S_MS * 1000 / EXEC_PERIOD_US;
   localparam int FAN_HOLD_S = 60;
   localparam int FAN_HOLD_TICKS = FAN_HOLD_S * 1_000_000 / EXEC_PERIOD_US;
   // Contactor timeout, in tenths of a second
   localparam logic [7:0] CDLY_RESET = 8'h64;
   localparam logic [7:0] CDLY_MIN = 8'h0a;
   localparam logic [7:0] CDLY_MAX = 8'h64;
   // Register byte offsets
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_CDLY = 4'h4;
   localparam logic [3:0] OFS_STAT = 4'h8;
   // Control register fields
   localparam int C_FWD = 0;
   localparam int C_REV = 1;
   localparam int C_JOG = 2;
   localparam int C_PERMIT = 3;
   localparam int C_QH_N = 4;
   localparam int C_FW_N = 5;
   localparam int C_REMOTE = 6;
   localparam int C_DIR_INV = 7;
   localparam int C_FCLR = 8;
   localparam int C_FCLR_RUN = 9;
   localparam int C_AUTOSTART = 10;
   localparam int C_WIDTH = 11;
   localparam logic [10:0] CTRL_RESET = 11'h238;
   // Status register fields
   localparam int S_FAULTED = 0;
   localparam int S_ACTIVE = 1;
   localparam int S_JOG = 2;
   localparam int S_HALTING = 3;
   localparam int S_RTS = 4;
   localparam int S_RUN_ACC = 5;
   localparam int S_READY = 6;
   localparam int S_ENTRY = 7;
   localparam int S_DREV = 8;
   localparam int S_HEALTHY = 9;
   localparam int S_FAN = 10;
   localparam int S_COIL = 11;
   localparam int S_CODE = 12;
   localparam int S_CFB_FAULT = 15;
   localparam int S_EXT_FAULT = 16;
   // Sequencer states, listed in code order 0..7
   typedef enum logic [2:0] {
      ST_START_DIS, ST_START_EN, ST_RUN_ACCEPTED, ST_READY,
      ST_ENABLED, ST_QHALT, ST_TRIP_ACT, ST_TRIPPED
   } drs_state_e;
endpackage
`default_nettype wire

// ==== hdl/drs_sequencer.sv ====
// Drive run sequencer: start/stop state machine with contactor timing.
// Assumes pin inputs are asynchronous and a single Avalon-MM master.
`timescale 1ns/1ns
`default_nettype none
module drs_sequencer
   import drs_pkg::*;
#(
   parameter int TICK_CYCLES = EXEC_CYCLES,
   parameter int FAN_TICKS = FAN_HOLD_TICKS,
   parameter int TENTH = TENTH_TICKS,
   parameter bit SMALL_FRAME = 1'b0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Avalon-MM slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Contactor and external conditions (pins)
   input wire logic contactor_closed,
   input wire logic at_zero_speed,
   input wire logic ext_trip,
   input wire logic heatsink_hot,
   input wire logic ambient_hot,
   input wire logic load_high,
   // Outputs to the drive
   output logic contactor_coil,
   output logic fan_request,
   output logic entry_pulse,
   output logic [2:0] state_code
);

   // Synchronised pins: closed, zero, trip, heat, ambient, load
   logic [5:0] pin_s1;
   logic [5:0] pin_s2;
   logic [10:0] ctrl;
   logic [7:0] cdly;
   logic [31:0] tick_cnt;
   logic tick;
   logic [2:0] state_q;
   drs_state_e state;
   drs_state_e next_state;
   logic fclr_prev;
   logic run_prev;
   logic armed;
   logic first_tick;
   logic qh_lat;
   logic fw_lat;
   logic cfb_fault;
   logic ext_fault;
   logic healthy;
   logic [23:0] ctc_timer;
   logic [23:0] ctc_limit;
   logic [31:0] fan_cnt;
   logic faulted;
   logic active_flag;
   logic jog_flag;
   logic halting_flag;
   logic rts_flag;
   logic run_accepted;
   logic ready_flag;
   logic demanded_reverse;

   // Two-flop synchronisers for all pins
   always_ff @(posedge mclk) begin
      pin_s1 <= {load_high, ambient_hot, heatsink_hot, ext_trip,
                 at_zero_speed, contactor_closed};
      pin_s2 <= pin_s1;
   end

   // Decoded command terms
   logic fwd, rev, jog, permit, qh_n, fw_n, remote, fbk, at_zero;
   logic run_raw, run_req, may_run, clr_evt, trip_evt, ctc_expired;
   always_comb begin
      fwd = ctrl[C_FWD];
      rev = ctrl[C_REV];
      jog = ctrl[C_JOG];
      permit = ctrl[C_PERMIT];
      qh_n = ctrl[C_QH_N];
      fw_n = ctrl[C_FW_N];
      remote = ctrl[C_REMOTE];
      fbk = pin_s2[0];
      at_zero = pin_s2[1];
      run_raw = fwd | rev | jog;
      may_run = permit & qh_n & fw_n & healthy & remote;
      run_req = may_run & ((fwd ^ rev) | jog);
      clr_evt = (ctrl[C_FCLR] & ~fclr_prev)
         | (ctrl[C_FCLR_RUN] & run_raw & ~run_prev);
      ctc_limit = 24'(cdly) * 24'(TENTH);
      ctc_expired = (state == ST_RUN_ACCEPTED) & ~fbk
         & (ctc_timer >= ctc_limit - 24'h1);
      trip_evt = ctc_expired | pin_s2[2];
   end

   // Execution cycle tick
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tick_cnt <= 32'h0;
         tick <= 1'b0;
      end else if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
         tick_cnt <= 32'h0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick <= 1'b0;
      end
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      case (state)
         ST_START_DIS: begin
            if (!qh_lat && !fw_lat && may_run)
               next_state = ST_START_EN;
         end
         ST_START_EN: begin
            if (!may_run || qh_lat || fw_lat)
               next_state = ST_START_DIS;
            else if (run_req && armed)
               next_state = ST_RUN_ACCEPTED;
         end
         ST_RUN_ACCEPTED: begin
            if (!run_req)
               next_state = ST_START_EN;
            else if (fbk)
               next_state = ST_READY;
         end
         ST_READY: begin
            if (!run_req)
               next_state = ST_START_EN;
            else
               next_state = ST_ENABLED;
         end
         ST_ENABLED: begin
            if (!permit || !fw_n)
               next_state = ST_START_DIS;
            else if (!qh_n)
               next_state = ST_QHALT;
            else if (!run_req)
               next_state = ST_START_EN;
         end
         ST_QHALT: begin
            if (at_zero)
               next_state = ST_START_DIS;
         end
         ST_TRIP_ACT: begin
            if (at_zero)
               next_state = ST_TRIPPED;
         end
         ST_TRIPPED: begin
            if (!cfb_fault && !ext_fault && !trip_evt)
               next_state = ST_START_DIS;
         end
         default: next_state = ST_START_DIS;
      endcase
      if (trip_evt && state != ST_TRIPPED && state != ST_TRIP_ACT)
         next_state = ST_TRIP_ACT;
   end

   // State register, advanced once per tick
   always_ff @(posedge mclk) begin
      if (!rst_n)
         state <= ST_START_DIS;
      else if (tick)
         state <= next_state;
   end
   assign state_q = state;

   // Edge history and autostart arming
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fclr_prev <= 1'b0;
         run_prev <= 1'b0;
         armed <= 1'b0;
         first_tick <= 1'b1;
      end else if (tick) begin
         fclr_prev <= ctrl[C_FCLR];
         run_prev <= run_raw;
         first_tick <= 1'b0;
         armed <= armed | ~run_raw
            | (first_tick & ctrl[C_AUTOSTART]);
      end
   end

   // Latched halts
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         qh_lat <= 1'b0;
         fw_lat <= 1'b0;
      end else if (tick) begin
         if (!qh_n && state == ST_ENABLED)
            qh_lat <= 1'b1;
         else if (at_zero)
            qh_lat <= 1'b0;
         if (!fw_n)
            fw_lat <= 1'b1;
         else if (at_zero)
            fw_lat <= 1'b0;
      end
   end

   // Latched trips; a new trip wins over a clear
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfb_fault <= 1'b0;
         ext_fault <= 1'b0;
      end else if (tick) begin
         if (ctc_expired)
            cfb_fault <= 1'b1;
         else if (clr_evt)
            cfb_fault <= 1'b0;
         if (pin_s2[2])
            ext_fault <= 1'b1;
         else if (clr_evt)
            ext_fault <= 1'b0;
      end
   end

   // Health flag
   always_ff @(posedge mclk) begin
      if (!rst_n)
         healthy <= 1'b1;
      else if (tick) begin
         if (trip_evt)
            healthy <= 1'b0;
         else if (!run_raw)
            healthy <= 1'b1;
      end
   end

   // Contactor feedback timer
   always_ff @(posedge mclk) begin
      if (!rst_n)
         ctc_timer <= 24'h0;
      else if (tick) begin
         if (state == ST_RUN_ACCEPTED)
            ctc_timer <= ctc_timer + 24'h1;
         else
            ctc_timer <= 24'h0;
      end
   end

   // Fan request with hold-off
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fan_cnt <= SMALL_FRAME ? 32'(FAN_TICKS) : 32'h0;
         fan_request <= SMALL_FRAME;
      end else if (tick) begin
         if (|pin_s2[5:3]) begin
            fan_cnt <= 32'(FAN_TICKS);
            fan_request <= 1'b1;
         end else if (fan_cnt != 32'h0) begin
            fan_cnt <= fan_cnt - 32'h1;
            fan_request <= 1'b1;
         end else
            fan_request <= 1'b0;
      end
   end

   // Status flags and outputs, registered from the next state and control bits
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         active_flag <= 1'b0;
         jog_flag <= 1'b0;
         halting_flag <= 1'b0;
         rts_flag <= 1'b0;
         run_accepted <= 1'b0;
         ready_flag <= 1'b0;
         entry_pulse <= 1'b0;
         contactor_coil <= 1'b0;
         state_code <= 3'h0;
         demanded_reverse <= 1'b0;
      end else if (tick) begin
         active_flag <= next_state == ST_ENABLED;
         jog_flag <= next_state == ST_ENABLED && jog && !(fwd ^ rev);
         halting_flag <= next_state == ST_QHALT
            || next_state == ST_TRIP_ACT;
         rts_flag <= next_state == ST_START_EN;
         run_accepted <= next_state == ST_RUN_ACCEPTED;
         ready_flag <= next_state == ST_READY
            || next_state == ST_ENABLED;
         entry_pulse <= next_state == ST_ENABLED
            && state != ST_ENABLED;
         contactor_coil <= next_state == ST_RUN_ACCEPTED
            || next_state == ST_READY
            || next_state == ST_ENABLED
            || next_state == ST_QHALT;
         state_code <= next_state;
         demanded_reverse <= rev ^ ctrl[C_DIR_INV];
      end
   end
   assign faulted = cfb_fault | ext_fault;

   // Bus handshake: one wait cycle, then the answer
   always_ff @(posedge mclk) begin
      if (!rst_n)
         avs_waitrequest <= 1'b1;
      else
         avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
   end

   // Register writes, taken when waitrequest is low
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl <= CTRL_RESET;
         cdly <= CDLY_RESET;
      end else if (avs_write && !avs_waitrequest) begin
         if (avs_address == OFS_CTRL)
            ctrl <= avs_writedata[C_WIDTH-1:0];
         else if (avs_address == OFS_CDLY) begin
            if (avs_writedata[7:0] < CDLY_MIN)
               cdly <= CDLY_MIN;
            else if (avs_writedata[7:0] > CDLY_MAX)
               cdly <= CDLY_MAX;
            else
               cdly <= avs_writedata[7:0];
         end
      end
   end

   // Read data, loaded in the wait cycle
   always_ff @(posedge mclk) begin
      if (!rst_n)
         avs_readdata <= 32'h0;
      else if (avs_read && avs_waitrequest) begin
         avs_readdata <= 32'h0;
         case (avs_address)
            OFS_CTRL: avs_readdata <= {21'h0, ctrl};
            OFS_CDLY: avs_readdata <= {24'h0, cdly};
            OFS_STAT: avs_readdata <= {15'h0, ext_fault, cfb_fault,
               state_q, contactor_coil, fan_request, healthy,
               demanded_reverse, entry_pulse, ready_flag, run_accepted,
               rts_flag, halting_flag, jog_flag, active_flag, faulted};
            default: avs_readdata <= 32'h0;
         endcase
      end
   end

   // Checks, all on the one system clock
   default clocking cb_chk @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   sequence s_in_swon;
      tick && state == ST_RUN_ACCEPTED;
   endsequence
   sequence s_fbk_seen;
      s_in_swon ##0 (fbk && run_req && !trip_evt);
   endsequence

   a_ready_on_fbk: assert property (
      s_fbk_seen |=> state == ST_READY)
      else $error("feedback did not advance to ready");
   a_both_dir_stop: assert property (
      (fwd && rev && !jog) |-> !run_req)
      else $error("both directions accepted as run");
   a_permit_coast: assert property (
      (tick && state == ST_ENABLED && !permit && !trip_evt)
      |=> state == ST_START_DIS)
      else $error("permit loss did not coast");
   a_qhalt_enter: assert property (
      (tick && state == ST_ENABLED && permit && fw_n && !qh_n && !trip_evt)
      |=> state == ST_QHALT && qh_lat)
      else $error("quick halt not entered");
   a_qhalt_hold: assert property (
      (state == ST_QHALT && !at_zero && !trip_evt) |=> state == ST_QHALT)
      else $error("quick halt left before zero");
   a_coil_swon: assert property (
      (state == ST_RUN_ACCEPTED && $past(tick)) |-> contactor_coil)
      else $error("coil off in run_accepted");
   a_ctc_trip: assert property (
      (tick && ctc_expired) |=> cfb_fault && state == ST_TRIP_ACT)
      else $error("contactor timeout did not trip");
   a_fault_flag: assert property (
      tick |=> faulted == ($past(trip_evt)
         || ($past(faulted) && !$past(clr_evt))))
      else $error("fault flag does not track latched trips");
   a_code_match: assert property (
      $past(tick) |-> state_code == state_q)
      else $error("state code differs from state");
   a_health_trip: assert property (
      (tick && trip_evt) |=> !healthy)
      else $error("health not cleared on trip");
   a_entry_once: assert property (
      (entry_pulse && tick) |=> !entry_pulse)
      else $error("entry pulse longer than one cycle");

endmodule // drs_sequencer
`default_nettype wire

// ==== tb/drs_contactor_model.sv ====
// Line contactor model: closes its feedback after the coil is energised.
// Assumes the coil output of the sequencer and a bench-driven enable.
`timescale 1ns/1ns
`default_nettype none
module drs_contactor_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Coil side and bench control
   input wire logic contactor_coil,
   input wire logic close_en,
   input wire logic slow,
   // Feedback to the sequencer
   output logic contactor_closed
);
   int cnt;
   // Feedback follows the coil after a prompt or a slow closing time
   always_ff @(posedge mclk) begin
      if (!rst_n || !contactor_coil) begin
         cnt <= 0;
         contactor_closed <= 1'b0;
      end else if (close_en) begin
         cnt <= cnt + 1;
         if (cnt >= (slow ? 30 : 3)) contactor_closed <= 1'b1;
      end
   end
endmodule // drs_contactor_model
`default_nettype wire

// ==== tb/drive_run_sequencer_tb.sv ====
// Self-checking bench for the drive run sequencer.
// Assumes shortened tick counts and the contactor model on the far side.
`timescale 1ns/1ns
`default_nettype none
module drive_run_sequencer_tb;
   import drs_pkg::*;
   localparam int TK = 4;
   localparam int FT = 5;
   localparam int TN = 2;
   typedef struct {
      logic [3:0] wa;
      logic [31:0] wd;
      logic [3:0] ra;
      logic [31:0] m;
      logic [31:0] e;
   } drs_row_s;
   logic mclk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic avs_waitrequest, contactor_closed, contactor_coil, fan_request;
   logic at_zero_speed = 1'b1, ext_trip = 1'b0, close_en = 1'b1;
   logic slow = 1'b1, entry_pulse;
   logic [2:0] hot = 3'h0;
   logic [2:0] state_code;
   int bad_count = 0, cmp_count = 0, n;
   drs_row_s rows [8];
   logic [31:0] cm [2];

   // Device under test with short execution cycle and timers
   drs_sequencer #(.TICK_CYCLES(TK), .FAN_TICKS(FT), .TENTH(TN),
      .SMALL_FRAME(1'b0)) u_drs_sequencer (
      .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .contactor_closed(contactor_closed), .at_zero_speed(at_zero_speed),
      .ext_trip(ext_trip), .heatsink_hot(hot[0]), .ambient_hot(hot[1]),
      .load_high(hot[2]), .contactor_coil(contactor_coil),
      .fan_request(fan_request), .entry_pulse(entry_pulse),
      .state_code(state_code));
   // Far-side contactor
   drs_contactor_model u_drs_contactor_model (.mclk(mclk), .rst_n(rst_n),
      .contactor_coil(contactor_coil), .close_en(close_en), .slow(slow),
      .contactor_closed(contactor_closed));

   // 125 MHz clock
   initial begin
      forever #4 mclk = ~mclk;
   end

   task automatic wrap_up;
      $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One Avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic [3:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] q);
      int k;
      k = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge mclk);
      while (avs_waitrequest !== 1'b0 && k < 50) begin
         @(posedge mclk);
         k++;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k >= 50) begin
         check(32'h1, 32'h0);
         wrap_up();
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rdc(input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      logic [31:0] q;
      bus(a, 1'b0, 32'h0, q);
      check(q & m, e);
   endtask

   // Waits whole execution cycles, ending off the rising edge
   task automatic ticks(input int t);
      repeat (t * TK) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic wait_code(input logic [2:0] c, output int k);
      k = 0;
      while (state_code !== c && k < 400) begin
         @(negedge mclk);
         k++;
      end
      if (k >= 400) begin
         check({29'h0, state_code}, {29'h0, c});
         wrap_up();
      end
   endtask

   // Remote forward run from a seen-low command
   task automatic run_up;
      int k;
      wr(OFS_CTRL, 32'h278);
      ticks(3);
      wr(OFS_CTRL, 32'h279);
      wait_code(ST_ENABLED, k);
   endtask

   // Reset, then a control word written before the first execution cycle
   task automatic pwr_up(input logic [31:0] c);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      check({28'h0, contactor_coil, state_code}, 32'h0);
      wr(OFS_CTRL, c);
      ticks(3);
   endtask

   initial begin
      rows = '{
         '{OFS_CDLY, 32'h05, OFS_CDLY, 32'hff, 32'h0a},
         '{OFS_CDLY, 32'hc8, OFS_CDLY, 32'hff, 32'h64},
         '{OFS_CDLY, 32'h32, OFS_CDLY, 32'hff, 32'h32},
         '{4'hc, 32'hff, 4'hc, 32'hffffffff, 32'h0},
         '{OFS_CTRL, 32'h23a, OFS_STAT, 32'h100, 32'h100},
         '{OFS_CTRL, 32'h2ba, OFS_STAT, 32'h100, 32'h0},
         '{OFS_CTRL, 32'h2b8, OFS_STAT, 32'h100, 32'h100},
         '{OFS_CTRL, 32'h238, OFS_STAT, 32'h100, 32'h0}};
      cm = '{32'h08, 32'h20};
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      @(negedge mclk);
      // Reset values
      check({29'h0, state_code}, 32'h0);
      check({29'h0, contactor_coil, entry_pulse, fan_request}, 32'h0);
      rdc(OFS_CTRL, 32'h7ff, 32'h238);
      rdc(OFS_CDLY, 32'hff, 32'h64);
      rdc(OFS_STAT, 32'h20e, 32'h200);
      // Table: timeout clamp, unmapped place, demanded direction
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         ticks(3);
         rdc(rows[i].ra, rows[i].m, rows[i].e);
      end
      // Full start with a slow contactor
      wr(OFS_CDLY, 32'h64);
      wr(OFS_CTRL, 32'h278);
      wait_code(ST_START_EN, n);
      rdc(OFS_STAT, 32'h10, 32'h10);
      wr(OFS_CTRL, 32'h279);
      wait_code(ST_RUN_ACCEPTED, n);
      check({31'h0, contactor_coil}, 32'h1);
      rdc(OFS_STAT, 32'h20, 32'h20);
      check({31'h0, contactor_closed}, 32'h0);
      wait_code(ST_ENABLED, n);
      n = 0;
      while (entry_pulse !== 1'b1 && n < 3 * TK) begin
         @(negedge mclk);
         n++;
      end
      n = 0;
      while (entry_pulse === 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      check(n, TK);
      rdc(OFS_STAT, 32'h7006, 32'h4002);
      // Forward and reverse together
      wr(OFS_CTRL, 32'h27b);
      ticks(3);
      check({31'h0, state_code === ST_ENABLED}, 32'h0);
      // Jog with both directions set still runs, flagged as jog
      wr(OFS_CTRL, 32'h27f);
      wait_code(ST_ENABLED, n);
      rdc(OFS_STAT, 32'h4, 32'h4);
      // Permit drop, then freewheel halt
      slow <= 1'b0;
      foreach (cm[i]) begin
         run_up();
         wr(OFS_CTRL, 32'h279 & ~cm[i]);
         ticks(3);
         rdc(OFS_STAT, 32'h2, 32'h0);
         check({31'h0, state_code === ST_ENABLED}, 32'h0);
      end
      // Quick halt latched until zero speed
      run_up();
      at_zero_speed <= 1'b0;
      wr(OFS_CTRL, 32'h269);
      wait_code(ST_QHALT, n);
      rdc(OFS_STAT, 32'h8, 32'h8);
      wr(OFS_CTRL, 32'h279);
      ticks(4);
      check({29'h0, state_code}, {29'h0, ST_QHALT});
      @(posedge mclk);
      at_zero_speed <= 1'b1;
      ticks(3);
      check({31'h0, state_code === ST_QHALT}, 32'h0);
      // Contactor never closes: timeout trip and clearing
      close_en <= 1'b0;
      wr(OFS_CDLY, 32'h0a);
      wr(OFS_CTRL, 32'h278);
      ticks(3);
      wr(OFS_CTRL, 32'h279);
      wait_code(ST_RUN_ACCEPTED, n);
      check({29'h0, state_code}, {29'h0, ST_RUN_ACCEPTED});
      wait_code(ST_TRIPPED, n);
      check({31'h0, n >= 10 * TN * TK - 2 * TK}, 32'h1);
      check({31'h0, n <= 10 * TN * TK + 4 * TK}, 32'h1);
      check({31'h0, contactor_coil}, 32'h0);
      rdc(OFS_STAT, 32'h8201, 32'h8001);
      wr(OFS_CTRL, 32'h278);
      ticks(3);
      rdc(OFS_STAT, 32'h201, 32'h201);
      wr(OFS_CTRL, 32'h378);
      ticks(3);
      rdc(OFS_STAT, 32'h8001, 32'h0);
      close_en <= 1'b1;
      // External trip cleared by a run rising edge
      wr(OFS_CTRL, 32'h278);
      @(posedge mclk);
      ext_trip <= 1'b1;
      ticks(2);
      @(posedge mclk);
      ext_trip <= 1'b0;
      ticks(3);
      rdc(OFS_STAT, 32'h10001, 32'h10001);
      wr(OFS_CTRL, 32'h279);
      ticks(3);
      rdc(OFS_STAT, 32'h10001, 32'h0);
      wr(OFS_CTRL, 32'h278);
      // Fan request from each condition, with hold-off
      for (int i = 0; i < 3; i++) begin
         @(posedge mclk);
         hot <= 3'h1 << i;
         ticks(3);
         check({31'h0, fan_request}, 32'h1);
         @(posedge mclk);
         hot <= 3'h0;
         ticks(2);
         check({31'h0, fan_request}, 32'h1);
         ticks(FT + 3);
         check({31'h0, fan_request}, 32'h0);
      end
      // Reset in mid-run, then run held through power-up
      run_up();
      pwr_up(32'h279);
      check({28'h0, contactor_coil, state_code}, 32'h1);
      pwr_up(32'h679);
      check({31'h0, contactor_coil}, 32'h1);
      wrap_up();
   end
endmodule // drive_run_sequencer_tb
`default_nettype wire
